//--- hdl/modrm_and_sysreg_field_decode.sv
// Addressing byte and system register selector decoder, one cycle of latency.
// Assumes fetch presents addressing byte and any index byte together with
// the address and operand size already resolved from prefixes.
`timescale 1ns/10ps
// Overview of operation
// RULE1 - Selector bits five to three choose system register
// RULE2 - Selector maps to listed control, debug, test registers
// RULE3 - Unlisted selector per class is invalid
// RULE4 - Invalid selector raises undefined opcode, no access
// RULE5 - Class and location fields pick the addressing
// RULE6 - Implied-mode instructions leave addressing byte uninterpreted
// RULE7 - Class 11 picks a register operand
// RULE8 - Sixteen-bit location table with displacement classes
// RULE9 - BP-based sixteen-bit forms use stack segment
// RULE10 - Displacement length one, two or four bytes
// RULE11 - Thirty-two-bit location table, index byte, direct form
// RULE12 - Index scaled by one, two, four, eight
// RULE13 - Register size from operation size and size bit
module modrm_and_sysreg_field_decode (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire decode_pkg::req_t req,
  output logic res_valid,
  output decode_pkg::res_t res
);

  // ****************************************
  // Field extraction
  // ****************************************
  wire logic [1:0] mod_f;
  wire logic [2:0] reg_f;
  wire logic [2:0] rm_f;
  wire logic [1:0] ss_f;
  wire logic [2:0] idx_f;
  wire logic [2:0] base_f;

  assign mod_f = req.modrm[decode_pkg::mod_hi:decode_pkg::mod_lo]; // [RULE5]
  assign reg_f = req.modrm[decode_pkg::reg_hi:decode_pkg::reg_lo]; // [RULE1]
  assign rm_f = req.modrm[decode_pkg::rm_hi:decode_pkg::rm_lo]; // [RULE5]
  assign ss_f = req.sib[decode_pkg::ss_hi:decode_pkg::ss_lo];
  assign idx_f = req.sib[decode_pkg::idx_hi:decode_pkg::idx_lo];
  assign base_f = req.sib[decode_pkg::base_hi:decode_pkg::base_lo];

  // ****************************************
  // Mode qualifiers
  // ****************************************
  wire logic mem_form;
  wire logic reg_form;
  wire logic is_sys_move;

  // Implied-mode instructions carry no addressing byte; nothing decodes  [RULE6]
  assign reg_form = req.has_modrm && (mod_f == decode_pkg::mod_register); // [RULE7]
  assign mem_form = req.has_modrm && (mod_f != decode_pkg::mod_register); // [RULE5]
  assign is_sys_move = req.has_modrm && (req.sys_kind != decode_pkg::sys_none);

  // ****************************************
  // Form classification
  // ****************************************
  wire logic form_implied;
  wire logic form_reg;
  wire logic form_mem32;

  // At most one form per request; implied carries only the operand sizes
  assign form_implied = !req.has_modrm; // [RULE6]
  assign form_reg = reg_form; // [RULE7]
  assign form_mem32 = mem_form && req.addr32; // [RULE11]

  // ****************************************
  // System register selector
  // ****************************************
  wire logic sys_legal;
  wire logic [2:0] sys_num;
  wire decode_pkg::sysreg_kind_t sys_kind_eff;

  // Selector is only looked at for register moves  [RULE1]
  assign sys_kind_eff = is_sys_move ? req.sys_kind : decode_pkg::sys_none;

  sysreg_sel_decode u_sel (
    .kind(sys_kind_eff),
    .sel(reg_f),
    .legal(sys_legal),
    .num(sys_num)
  );

  wire logic ud_fault;
  // Illegal selector faults instead of touching any register  [RULE4]
  assign ud_fault = is_sys_move && !sys_legal;

  // ****************************************
  // Register operand sizes
  // ****************************************
  wire decode_pkg::opnd_size_t wide_size;
  wire decode_pkg::opnd_size_t opnd_size;

  // Byte registers at size bit 0, word or dword at 1  [RULE13]
  assign wide_size = req.op32 ? decode_pkg::opnd_dword : decode_pkg::opnd_word;
  assign opnd_size = req.size_sel ? wide_size : decode_pkg::opnd_byte; // [RULE13]

  // ****************************************
  // Sixteen-bit addressing
  // ****************************************
  wire logic a16_direct;
  wire logic a16_base_used;
  wire logic [2:0] a16_base;
  wire logic a16_index_used;
  wire logic [2:0] a16_index;
  wire logic [2:0] a16_disp;
  wire decode_pkg::seg_t a16_seg;

  // Class 00 with location 110 is a bare two-byte displacement  [RULE8]
  assign a16_direct = (mod_f == decode_pkg::mod_no_disp) && (rm_f == decode_pkg::rm16_direct);

  // Base: BX for 000/001/111, BP for 010/011/110, none for SI/DI alone  [RULE8]
  assign a16_base_used = !a16_direct && ((rm_f[2] == 1'b0) || (rm_f[1] == 1'b1));
  assign a16_base = (rm_f == 3'h7) ? decode_pkg::gpr_bx :
                    (rm_f == 3'h6) ? decode_pkg::gpr_bp :
                    (rm_f[1] == 1'b1) ? decode_pkg::gpr_bp : decode_pkg::gpr_bx;

  // Index: SI for even, DI for odd in 000..011; lone SI/DI at 100/101  [RULE8]
  assign a16_index_used = (rm_f[2] == 1'b0) || (rm_f[2:1] == 2'b10);
  assign a16_index = rm_f[0] ? decode_pkg::gpr_di : decode_pkg::gpr_si;

  // BP-based forms take the stack segment; direct uses data  [RULE9]
  assign a16_seg = (a16_base_used && (a16_base == decode_pkg::gpr_bp)) ?
                   decode_pkg::seg_stack : decode_pkg::seg_data;

  // One byte for class 01, two bytes for class 10 or direct  [RULE8] [RULE10]
  assign a16_disp = (mod_f == decode_pkg::mod_disp_short) ? decode_pkg::disp_one_byte :
                    (mod_f == decode_pkg::mod_disp_long) ? decode_pkg::disp_two_byte :
                    a16_direct ? decode_pkg::disp_two_byte : decode_pkg::disp_none;

  // ****************************************
  // Thirty-two-bit addressing
  // ****************************************
  wire logic a32_sib;
  wire logic a32_direct;
  wire logic sib_direct;
  wire logic a32_base_used;
  wire logic [2:0] a32_base;
  wire logic a32_index_used;
  wire logic [2:0] a32_index;
  wire logic [2:0] a32_disp;
  wire decode_pkg::seg_t a32_seg;

  // Location 100 means an index byte follows  [RULE11]
  assign a32_sib = (rm_f == decode_pkg::rm32_sib);
  // Class 00 location 101 is a bare four-byte displacement  [RULE11]
  assign a32_direct = (mod_f == decode_pkg::mod_no_disp) && (rm_f == decode_pkg::rm32_direct);
  // Index byte with base 101 and class 00 also drops the base
  assign sib_direct = a32_sib && (mod_f == decode_pkg::mod_no_disp) && (base_f == decode_pkg::sib_base_direct);

  assign a32_base_used = a32_sib ? !sib_direct : !a32_direct; // [RULE11]
  assign a32_base = a32_sib ? base_f : rm_f; // [RULE11]

  // Index 100 means no index register
  assign a32_index_used = a32_sib && (idx_f != decode_pkg::sib_no_index);
  assign a32_index = a32_index_used ? idx_f : 3'h0;

  // EBP and ESP bases default to the stack segment  [RULE11]
  assign a32_seg = (a32_base_used && ((a32_base == decode_pkg::gpr_bp) || (a32_base == decode_pkg::gpr_sp))) ?
                   decode_pkg::seg_stack : decode_pkg::seg_data;

  // One byte for class 01, four for class 10 or either direct form  [RULE11] [RULE10]
  assign a32_disp = (mod_f == decode_pkg::mod_disp_short) ? decode_pkg::disp_one_byte :
                    (mod_f == decode_pkg::mod_disp_long) ? decode_pkg::disp_four_byte :
                    (a32_direct || sib_direct) ? decode_pkg::disp_four_byte : decode_pkg::disp_none;

  // ****************************************
  // Scaled index
  // ****************************************
  wire logic [31:0] scaled_index;

  // Shift by ss gives x1, x2, x4, x8 before the offset adder  [RULE12]
  assign scaled_index = a32_index_used ? (req.index_value << ss_f) : 32'h0000_0000;

  // ****************************************
  // Memory form selection
  // ****************************************
  wire logic mem_base_used;
  wire logic [2:0] mem_base;
  wire logic mem_index_used;
  wire logic [2:0] mem_index;
  wire logic [1:0] mem_scale;
  wire logic [31:0] mem_scaled;
  wire decode_pkg::seg_t mem_seg;
  wire logic [2:0] mem_disp;
  wire logic mem_sib;

  // Address size picks the table; index byte exists only in 32-bit mode
  assign mem_base_used = req.addr32 ? a32_base_used : a16_base_used;
  assign mem_base = !mem_base_used ? 3'h0 :
                    req.addr32 ? a32_base : a16_base;
  assign mem_index_used = req.addr32 ? a32_index_used : a16_index_used;
  assign mem_index = !mem_index_used ? 3'h0 :
                     req.addr32 ? a32_index : a16_index;
  // Sixteen-bit forms never scale, so the adder sees zero there  [RULE12]
  assign mem_scale = (form_mem32 && a32_index_used) ? ss_f : 2'h0;
  assign mem_scaled = form_mem32 ? scaled_index : 32'h0000_0000;
  assign mem_seg = req.addr32 ? a32_seg : a16_seg; // [RULE9] [RULE11]
  assign mem_disp = req.addr32 ? a32_disp : a16_disp; // [RULE10]
  assign mem_sib = form_mem32 && a32_sib;

  // ****************************************
  // Fault result
  // ****************************************
  decode_pkg::res_t fault_res;

  // A faulting move accesses nothing; keep only the fault  [RULE4]
  always_comb begin
    fault_res = '0;
    fault_res.seg = decode_pkg::seg_data;
    fault_res.ud_fault = 1'b1;
  end

  // ****************************************
  // Result assembly
  // ****************************************
  decode_pkg::res_t raw_res;
  wire decode_pkg::res_t res_d;

  always_comb begin
    raw_res = '0;
    raw_res.seg = decode_pkg::seg_data;
    raw_res.reg_field = form_implied ? 3'h0 : reg_f;
    raw_res.reg_size = opnd_size; // [RULE13]
    raw_res.rm_size = opnd_size;
    raw_res.sys_valid = is_sys_move && sys_legal; // [RULE2]
    raw_res.sys_num = sys_num;
    raw_res.ud_fault = ud_fault; // [RULE4]
    if (form_reg) begin
      // Register chosen by location field and size bit  [RULE7]
      raw_res.is_reg_operand = 1'b1;
      raw_res.rm_reg = rm_f;
    end else if (mem_form) begin
      raw_res.base_used = mem_base_used;
      raw_res.base_reg = mem_base;
      raw_res.index_used = mem_index_used;
      raw_res.index_reg = mem_index;
      raw_res.scale_log2 = mem_scale; // [RULE12]
      raw_res.scaled_index = mem_scaled;
      raw_res.seg = mem_seg;
      raw_res.disp_bytes = mem_disp;
      raw_res.sib_present = mem_sib;
    end
  end

  // Fault wins over every decoded field  [RULE4]
  assign res_d = ud_fault ? fault_res : raw_res;

  // ****************************************
  // Output stage
  // ****************************************
  // Registered so the address stage sees a clean one-cycle boundary.
  decode_pkg::res_t res_q;
  logic res_valid_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      res_valid_q <= 1'b0;
    end else begin
      res_valid_q <= req_valid;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      res_q <= '0;
    end else if (req_valid) begin
      res_q <= res_d;
    end
  end

  assign res_valid = res_valid_q;
  assign res = res_q;

endmodule : modrm_and_sysreg_field_decode

//--- hdl/decode_pkg.sv
// Shared constants and carrier types for the addressing-byte and
// system-register selector decoder.
// Assumes a single core clock and byte fields supplied by the fetch stage.
package decode_pkg;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int mod_hi = 7;
  localparam int mod_lo = 6;
  localparam int reg_hi = 5;
  localparam int reg_lo = 3;
  localparam int rm_hi = 2;
  localparam int rm_lo = 0;
  localparam int ss_hi = 7;
  localparam int ss_lo = 6;
  localparam int idx_hi = 5;
  localparam int idx_lo = 3;
  localparam int base_hi = 2;
  localparam int base_lo = 0;

  // ****************************************
  // Field codes
  // ****************************************
  localparam logic [1:0] mod_no_disp = 2'h0;
  localparam logic [1:0] mod_disp_short = 2'h1;
  localparam logic [1:0] mod_disp_long = 2'h2;
  localparam logic [1:0] mod_register = 2'h3;
  localparam logic [2:0] rm16_direct = 3'h6;
  localparam logic [2:0] rm32_sib = 3'h4;
  localparam logic [2:0] rm32_direct = 3'h5;
  localparam logic [2:0] sib_no_index = 3'h4;
  localparam logic [2:0] sib_base_direct = 3'h5;

  // General register numbers
  localparam logic [2:0] gpr_bx = 3'h3;
  localparam logic [2:0] gpr_sp = 3'h4;
  localparam logic [2:0] gpr_bp = 3'h5;
  localparam logic [2:0] gpr_si = 3'h6;
  localparam logic [2:0] gpr_di = 3'h7;

  // Displacement length in bytes
  localparam logic [2:0] disp_none = 3'h0;
  localparam logic [2:0] disp_one_byte = 3'h1;
  localparam logic [2:0] disp_two_byte = 3'h2;
  localparam logic [2:0] disp_four_byte = 3'h4;

  // ****************************************
  // System register selectors
  // ****************************************
  localparam logic [2:0] control_reg_zero = 3'h0;
  localparam logic [2:0] debug_reg_seven = 3'h7;
  localparam logic [2:0] test_reg_three = 3'h3;
  // One bit per selector value that is legal for the class
  localparam logic [7:0] control_sel_mask = 8'h1d;
  localparam logic [7:0] debug_sel_mask = 8'hcf;
  localparam logic [7:0] test_sel_mask = 8'hf8;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {seg_data = 2'h1, seg_stack = 2'h2} seg_t;
  typedef enum logic [1:0] {sys_none, sys_control, sys_debug, sys_test} sysreg_kind_t;
  typedef enum logic [1:0] {opnd_byte, opnd_word, opnd_dword} opnd_size_t;

  typedef struct packed {
    logic has_modrm;
    logic addr32;
    logic op32;
    logic size_sel;
    sysreg_kind_t sys_kind;
    logic [7:0] modrm;
    logic [7:0] sib;
    logic [31:0] index_value;
  } req_t;

  typedef struct packed {
    logic is_reg_operand;
    logic [2:0] rm_reg;
    opnd_size_t rm_size;
    logic [2:0] reg_field;
    opnd_size_t reg_size;
    logic base_used;
    logic [2:0] base_reg;
    logic index_used;
    logic [2:0] index_reg;
    logic [1:0] scale_log2;
    logic [31:0] scaled_index;
    seg_t seg;
    logic [2:0] disp_bytes;
    logic sib_present;
    logic sys_valid;
    logic [2:0] sys_num;
    logic ud_fault;
  } res_t;

endpackage : decode_pkg

//--- hdl/sysreg_sel_decode.sv
// Combinational check of the three-bit system register selector.
// Assumes the class comes from the opcode decode of a register move.
`timescale 1ns/10ps
module sysreg_sel_decode (
  input wire decode_pkg::sysreg_kind_t kind,
  input wire logic [2:0] sel,
  output logic legal,
  output logic [2:0] num
);

  // ****************************************
  // Legal selector masks
  // ****************************************
  wire logic [7:0] mask;

  assign mask = (kind == decode_pkg::sys_control) ? decode_pkg::control_sel_mask :
                (kind == decode_pkg::sys_debug) ? decode_pkg::debug_sel_mask :
                (kind == decode_pkg::sys_test) ? decode_pkg::test_sel_mask : 8'h00;

  // Only listed selectors pass; the rest are illegal encodings  [RULE2] [RULE3]
  assign legal = mask[sel];
  // Register number equals the selector for every legal code  [RULE2]
  assign num = legal ? sel : 3'h0;

endmodule : sysreg_sel_decode

//--- verification/modrm_and_sysreg_field_decode_chk.sv
// Assertion checker for the addressing-byte and selector decoder.
// Assumes one clock and the decoder's one-cycle answer latency.
`timescale 1ns/10ps
module modrm_and_sysreg_field_decode_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire decode_pkg::req_t req,
  input wire logic res_valid,
  input wire decode_pkg::res_t res
);
  wire [1:0] md = req.modrm[7:6];
  wire [2:0] rm = req.modrm[2:0];
  wire [2:0] sel = req.modrm[5:3];
  wire sys_mv = req_valid && req.has_modrm && req.sys_kind != decode_pkg::sys_none;
  wire plain = req_valid && req.has_modrm && req.sys_kind == decode_pkg::sys_none;
  wire mem16 = plain && !req.addr32 && md != 2'h3;
  wire mem32 = plain && req.addr32 && md != 2'h3;
  // Own copy of the legal sets, not the package masks
  wire sel_ok = (req.sys_kind == decode_pkg::sys_control) ? (sel inside {3'h0, 3'h2, 3'h3, 3'h4}) :
    (req.sys_kind == decode_pkg::sys_debug) ? (sel inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7}) : (sel >= 3'h3);
  // ****************
  // Properties
  // ****************
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_ONE_CYCLE: assert property (res_valid == $past(req_valid && rst_n))
    else $error("result strobe not one cycle after request");
  AST_SEL_NUM: assert property (sys_mv && sel_ok |=> res.sys_valid && res.sys_num == $past(sel))
    else $error("selector number wrong");
  AST_SEL_MAP: assert property (sys_mv |=> res.sys_valid == $past(sel_ok))
    else $error("selector legality wrong");
  AST_SEL_BAD: assert property (sys_mv && !sel_ok |=> res.ud_fault && res.disp_bytes == 3'h0)
    else $error("bad selector not faulted");
  AST_IMPLIED: assert property (req_valid && !req.has_modrm |=> !res.is_reg_operand && res.disp_bytes == 3'h0)
    else $error("implied form decoded fields");
  AST_REG_OP: assert property (plain && md == 2'h3 |=> res.is_reg_operand && res.rm_reg == $past(rm))
    else $error("register operand wrong");
  AST_SEG16: assert property (mem16 |=> res.seg == ($past(rm inside {3'h2, 3'h3} || (rm == 3'h6 && md != 2'h0)) ?
    decode_pkg::seg_stack : decode_pkg::seg_data)) else $error("16-bit segment wrong");
  AST_DISP16: assert property (mem16 |=> res.disp_bytes ==
    $past(md == 2'h1 ? 3'h1 : (md == 2'h2 || rm == 3'h6) ? 3'h2 : 3'h0)) else $error("16-bit disp wrong");
  AST_DISP32: assert property (mem32 && (md != 2'h0 || rm != 3'h4) |=> res.disp_bytes ==
    $past(md == 2'h1 ? 3'h1 : (md == 2'h2 || rm == 3'h5) ? 3'h4 : 3'h0)) else $error("32-bit disp wrong");
  AST_SCALE: assert property (mem32 && rm == 3'h4 && req.sib[5:3] != 3'h4 |=>
    res.scaled_index == $past(req.index_value << req.sib[7:6])) else $error("scaled index wrong");
  AST_SIZE: assert property (plain |=> res.reg_size ==
    $past(!req.size_sel ? decode_pkg::opnd_byte : req.op32 ? decode_pkg::opnd_dword : decode_pkg::opnd_word))
    else $error("operand size wrong");
  COV_FAULT: cover property (sys_mv && !sel_ok);
  COV_REG: cover property (plain && md == 2'h3);
  COV_SIB: cover property (mem32 && rm == 3'h4);
endmodule : modrm_and_sysreg_field_decode_chk
bind modrm_and_sysreg_field_decode modrm_and_sysreg_field_decode_chk chk_i (.mclk(mclk), .rst_n(rst_n),
  .req_valid(req_valid), .req(req), .res_valid(res_valid), .res(res));

//--- verification/agu_sink.sv
// Stand-in for the address generation stage that takes each result.
// Assumes a result is offered for exactly one cycle.
`timescale 1ns/10ps
module agu_sink (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic res_valid,
  input wire decode_pkg::res_t res,
  output int n_taken_q,
  output decode_pkg::res_t last_q
);
  always @(posedge mclk) begin
    if (!rst_n) begin
      n_taken_q <= 0;
    end else if (res_valid) begin
      n_taken_q <= n_taken_q + 1;
      last_q <= res;
    end
  end
endmodule : agu_sink

//--- verification/modrm_and_sysreg_field_decode_tb.sv
// Self-checking bench for the addressing-byte and selector decoder.
// Assumes a one-cycle answer and back-to-back requests being legal.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
  $display("mismatch %s exp %0h got %0h", nm, exp, got); end end
module modrm_and_sysreg_field_decode_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  decode_pkg::req_t req = '0;
  logic res_valid;
  decode_pkg::res_t res;
  decode_pkg::res_t last_q;
  int n_taken_q;
  int err_total = 0;
  int n_compared = 0;
  int n_sent = 0;
  always #2 mclk = ~mclk;
  modrm_and_sysreg_field_decode modrm_and_sysreg_field_decode_i (.mclk(mclk), .rst_n(rst_n),
    .req_valid(req_valid), .req(req), .res_valid(res_valid), .res(res));
  agu_sink agu_sink_i (.mclk(mclk), .rst_n(rst_n), .res_valid(res_valid), .res(res), .n_taken_q(n_taken_q),
    .last_q(last_q));
  // ****************
  // Drivers
  // ****************
  function automatic decode_pkg::req_t mk(input logic a32, input logic [1:0] md, input logic [2:0] sl,
    input logic [2:0] rm);
    mk = '0;
    mk.has_modrm = 1'b1;
    mk.addr32 = a32;
    mk.modrm = {md, sl, rm};
  endfunction : mk
  // Strobe stays up between calls, so loops give back-to-back traffic
  task automatic send(input decode_pkg::req_t r);
    req = r;
    req_valid = 1'b1;
    n_sent++;
    @(posedge mclk);
    #1;
    `CHK("res_valid", 1'b1, res_valid)
  endtask : send
  task automatic idle;
    req_valid = 1'b0;
    @(posedge mclk);
    #1;
  endtask : idle
  // ****************
  // Scenarios
  // ****************
  task automatic t_sysreg;
    decode_pkg::req_t r;
    logic ok;
    for (int k = 1; k < 4; k++) begin
      for (int s = 0; s < 8; s++) begin
        r = mk(1'b0, 2'h0, s[2:0], 3'h0);
        r.sys_kind = decode_pkg::sysreg_kind_t'(k);
        ok = (k == 1) ? (s inside {0, 2, 3, 4}) : (k == 2) ? (s inside {0, 1, 2, 3, 6, 7}) : (s >= 3);
        send(r);
        `CHK("sys_valid", ok, res.sys_valid)
        `CHK("ud_fault", !ok, res.ud_fault)
        if (ok) `CHK("sys_num", s[2:0], res.sys_num)
      end
    end
    idle();
    $display("test sysreg done");
  endtask : t_sysreg
  task automatic t_mem(input logic a32);
    logic st;
    logic [2:0] dn;
    for (int m = 0; m < 3; m++) begin
      for (int p = 0; p < 8; p++) begin
        if (!(a32 && p == 4)) begin
          send(mk(a32, m[1:0], 3'h2, p[2:0]));
          st = a32 ? (p == 5 && m != 0) : (p == 2 || p == 3 || (p == 6 && m != 0));
          dn = (m == 1) ? 3'h1 : (m == 2 || p == (a32 ? 5 : 6)) ? (a32 ? 3'h4 : 3'h2) : 3'h0;
          `CHK("mem reg_op", 1'b0, res.is_reg_operand)
          `CHK("mem seg", st ? decode_pkg::seg_stack : decode_pkg::seg_data, res.seg)
          `CHK("mem disp", dn, res.disp_bytes)
          if (m == 0 && p == (a32 ? 5 : 6)) `CHK("direct base", 1'b0, res.base_used)
          else if (a32) `CHK("base_reg", p[2:0], res.base_reg)
        end
      end
    end
    idle();
    $display("test mem done");
  endtask : t_mem
  task automatic t_sib;
    decode_pkg::req_t r;
    for (int q = 0; q < 4; q++) begin
      r = mk(1'b1, 2'h0, 3'h0, 3'h4);
      r.sib = {q[1:0], 3'h6, 3'h0};
      r.index_value = 32'h0000_0013;
      send(r);
      `CHK("scaled", 32'h0000_0013 << q, res.scaled_index)
      `CHK("sib_present", 1'b1, res.sib_present)
      `CHK("index_reg", 3'h6, res.index_reg)
      `CHK("scale", q[1:0], res.scale_log2)
    end
    r = mk(1'b1, 2'h1, 3'h0, 3'h4);
    r.sib = {2'h0, 3'h4, 3'h5};
    send(r);
    `CHK("no index", 1'b0, res.index_used)
    `CHK("sib stack", decode_pkg::seg_stack, res.seg)
    `CHK("sib disp", 3'h1, res.disp_bytes)
    idle();
    $display("test sib done");
  endtask : t_sib
  task automatic t_regop;
    decode_pkg::req_t r;
    decode_pkg::opnd_size_t sz;
    for (int i = 0; i < 32; i++) begin
      r = mk(i[4], 2'h3, ~i[2:0], i[2:0]);
      r.op32 = i[4];
      r.size_sel = i[3];
      sz = !i[3] ? decode_pkg::opnd_byte : i[4] ? decode_pkg::opnd_dword : decode_pkg::opnd_word;
      send(r);
      `CHK("reg_op", 1'b1, res.is_reg_operand)
      `CHK("rm_reg", i[2:0], res.rm_reg)
      `CHK("reg_field", ~i[2:0], res.reg_field)
      `CHK("rm_size", sz, res.rm_size)
      `CHK("reg_size", sz, res.reg_size)
    end
    idle();
    $display("test regop done");
  endtask : t_regop
  task automatic t_implied;
    decode_pkg::req_t r;
    r = mk(1'b0, 2'h1, 3'h0, 3'h6);
    r.has_modrm = 1'b0;
    send(r);
    `CHK("implied disp", 3'h0, res.disp_bytes)
    `CHK("implied base", 1'b0, res.base_used)
    send(mk(1'b0, 2'h1, 3'h0, 3'h6));
    idle();
    `CHK("idle strobe", 1'b0, res_valid)
    `CHK("held disp", 3'h1, res.disp_bytes)
    `CHK("sink last", 3'h1, last_q.disp_bytes)
    $display("test implied done");
  endtask : t_implied
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (4) @(posedge mclk);
    #1;
    `CHK("reset strobe", 1'b0, res_valid)
    `CHK("reset result", '0, res)
    rst_n = 1'b1;
    t_sysreg();
    t_mem(1'b0);
    t_mem(1'b1);
    t_sib();
    t_regop();
    t_implied();
    `CHK("sink count", n_sent, n_taken_q)
    close_out();
  end
  // Run needs about 120 cycles; this leaves ample margin
  initial begin
    #8000;
    err_total++;
    close_out();
  end
endmodule : modrm_and_sysreg_field_decode_tb
